// ==== logic/watchdog_reset_timer.sv ====
// Watchdog counter, reset generator and system control register
//
// Operation
// [RL1] A 16-bit free-running up-counter resets the device when it overflows.
// [RL2] The counter stays idle until software writes one to the enable bit, then counts on the divided time base.
// [RL3] The enable bit returns to zero after any reset, hardware or watchdog.
// [RL4] Writing one to the clear bit zeroes the count and restarts counting.
// [RL5] Prescale codes 000 to 111 divide the clock by 8 up to 1024; the timeout is one full 16-bit count of that clock.
// [RL6] An overflow reset sets the watchdog reset flag in the system control register.
// [RL7] Software must write the clear bit more often than the selected timeout.
// [RL8] Software should read the watchdog reset flag after an unexpected reset.
// [RL9] The quiet bit in the system control register silences the divide-by-six strobe clock.
// [RL10] The clear bit reads zero; the reset flag stays until software clears it or a hardware reset.
`timescale 1ns/100ps
`default_nettype none

module watchdog_reset_timer #(
  parameter int COUNT_W = dog_pkg::COUNT_W,
  parameter int BITE_CYCLES = dog_pkg::BITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic dog_reset_out,
  output logic strobe_clk_out,
  output logic irq
);

  if (COUNT_W < 2 || COUNT_W > 2 * 8) begin : g_bad_count_w
    $error("watchdog_reset_timer: COUNT_W must be 2 to 16");
  end
  if (BITE_CYCLES < 1 || BITE_CYCLES > 255) begin : g_bad_bite_cycles
    $error("watchdog_reset_timer: BITE_CYCLES must be 1 to 255");
  end

  localparam logic [COUNT_W-1:0] COUNT_TOP = '1;
  localparam logic [COUNT_W-1:0] COUNT_HALF = COUNT_W'(1) << (COUNT_W - 1);
  localparam logic [7:0] BITE_LAST = 8'(BITE_CYCLES - 1);
  localparam logic [2:0] STROBE_LAST = 3'(dog_pkg::STROBE_HALF - 1);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : hit

  // Register decode
  wire logic sel_ctrl = hit(reg_addr, dog_pkg::DOG_CONTROL_ADDR);
  wire logic sel_sys = hit(reg_addr, dog_pkg::SYSTEM_CONTROL_ADDR);
  wire logic sel_stat = hit(reg_addr, dog_pkg::IRQ_STATUS_ADDR);
  wire logic sel_mask = hit(reg_addr, dog_pkg::IRQ_MASK_ADDR);
  wire logic sel_cnt_lo = hit(reg_addr, dog_pkg::COUNT_LOW_ADDR);
  wire logic sel_cnt_hi = hit(reg_addr, dog_pkg::COUNT_HIGH_ADDR);

  wire logic wr_ctrl = reg_wr && sel_ctrl;
  wire logic wr_sys = reg_wr && sel_sys;
  wire logic wr_stat = reg_wr && sel_stat;
  wire logic wr_mask = reg_wr && sel_mask;

  wire logic set_enable = wr_ctrl && reg_wdata[dog_pkg::ENABLE_POS];
  wire logic clear_req = wr_ctrl && reg_wdata[dog_pkg::CLEAR_POS];
  wire logic [dog_pkg::PRESCALE_W-1:0] wr_prescale =
    reg_wdata[dog_pkg::PRESCALE_LSB +: dog_pkg::PRESCALE_W];

  // State
  dog_pkg::dog_state_t state_q;
  dog_pkg::dog_state_t state_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [dog_pkg::PRESCALE_W-1:0] prescale_q;
  logic [dog_pkg::PRESCALE_W-1:0] prescale_d;
  logic [7:0] bite_q;
  logic [7:0] bite_d;
  logic flag_q;
  logic flag_d;
  logic quiet_q;
  logic quiet_d;
  logic [dog_pkg::EV_W-1:0] status_q;
  logic [dog_pkg::EV_W-1:0] status_d;
  logic [dog_pkg::EV_W-1:0] mask_q;
  logic [dog_pkg::EV_W-1:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] strobe_cnt_q;
  logic [2:0] strobe_cnt_d;
  logic strobe_q;
  logic strobe_d;

  wire logic running = state_q == dog_pkg::DOG_RUN;
  wire logic biting = state_q == dog_pkg::DOG_BITE;
  wire logic enabled = !(state_q == dog_pkg::DOG_IDLE);
  wire logic tick;

  // Time base; a clear write restarts the divider too
  dog_prescaler #(
    .BASE_LOG2(dog_pkg::PRESCALE_BASE_LOG2),
    .MAX_LOG2(dog_pkg::PRESCALE_MAX_LOG2),
    .SEL_W(dog_pkg::PRESCALE_W)
  ) u_prescaler (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(running),
    .restart(clear_req), // [RL4]
    .select(prescale_q), // [RL5]
    .tick(tick)
  );

  wire logic overflow = running && !clear_req && tick && count_q == COUNT_TOP; // [RL1] [RL5]
  wire logic halfway = running && !clear_req && tick && count_q == COUNT_HALF - 1'b1;
  wire logic bite_done = biting && bite_q == BITE_LAST;

  // Sequencer: idle until enabled, run, then hold the device in reset
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dog_pkg::DOG_IDLE: begin
        if (set_enable) begin
          state_d = dog_pkg::DOG_RUN; // [RL2]
        end
      end
      dog_pkg::DOG_RUN: begin
        if (overflow) begin
          state_d = dog_pkg::DOG_BITE; // [RL1]
        end
      end
      dog_pkg::DOG_BITE: begin
        if (bite_done) begin
          state_d = dog_pkg::DOG_IDLE; // [RL3]
        end
      end
      default: begin
        state_d = dog_pkg::DOG_IDLE;
      end
    endcase
  end

  // Counter
  always_comb begin
    count_d = count_q;
    if (!running || clear_req) begin
      count_d = '0; // [RL4]
    end else if (tick) begin
      count_d = count_q + 1'b1; // [RL1]
    end
  end

  assign bite_d = biting ? bite_q + 8'h01 : 8'h00;

  // Prescale field is written freely; a watchdog reset returns it to its reset code
  assign prescale_d = bite_done ? dog_pkg::PRESCALE_RESET : (wr_ctrl ? wr_prescale : prescale_q);

  // Reset cause flag: overflow wins over a software clear
  always_comb begin
    flag_d = flag_q;
    if (wr_sys) begin
      flag_d = reg_wdata[dog_pkg::DOG_FLAG_POS];
    end
    if (overflow) begin
      flag_d = 1'b1; // [RL6] [RL10]
    end
  end

  assign quiet_d = bite_done ? 1'b0 : (wr_sys ? reg_wdata[dog_pkg::QUIET_POS] : quiet_q);

  // Interrupt status: write one to clear, a new event wins
  wire logic [dog_pkg::EV_W-1:0] events = {halfway, overflow};
  wire logic [dog_pkg::EV_W-1:0] clear_bits =
    wr_stat ? reg_wdata[dog_pkg::EV_W-1:0] : dog_pkg::EV_RESET;
  assign status_d = (status_q & ~clear_bits) | events;
  assign mask_d = wr_mask ? reg_wdata[dog_pkg::EV_W-1:0] : mask_q;

  // Read mux
  wire logic [7:0] ctrl_view = {enabled, 1'b0, 1'b0, 2'b00, prescale_q}; // [RL10]
  wire logic [7:0] sys_view = {flag_q, 6'h00, quiet_q};
  wire logic [7:0] stat_view = {{(8 - dog_pkg::EV_W){1'b0}}, status_q};
  wire logic [7:0] mask_view = {{(8 - dog_pkg::EV_W){1'b0}}, mask_q};
  wire logic [15:0] count_view = 16'(count_q);

  always_comb begin
    rdata_d = dog_pkg::BYTE_ZERO;
    if (reg_rd) begin
      if (sel_ctrl) begin
        rdata_d = ctrl_view;
      end else if (sel_sys) begin
        rdata_d = sys_view; // [RL6]
      end else if (sel_stat) begin
        rdata_d = stat_view;
      end else if (sel_mask) begin
        rdata_d = mask_view;
      end else if (sel_cnt_lo) begin
        rdata_d = count_view[7:0];
      end else if (sel_cnt_hi) begin
        rdata_d = count_view[15:8];
      end
    end
  end

  // Divide-by-six strobe clock, held low while quiet
  wire logic strobe_wrap = strobe_cnt_q == STROBE_LAST;
  assign strobe_cnt_d = strobe_wrap ? 3'h0 : strobe_cnt_q + 3'h1;
  assign strobe_d = quiet_q ? 1'b0 : (strobe_wrap ? !strobe_q : strobe_q); // [RL9]

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= dog_pkg::DOG_IDLE; // [RL3]
      count_q <= '0;
      bite_q <= 8'h00;
      prescale_q <= dog_pkg::PRESCALE_RESET;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      bite_q <= bite_d;
      prescale_q <= prescale_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0; // [RL10]
      quiet_q <= 1'b0;
      status_q <= dog_pkg::EV_RESET;
      mask_q <= dog_pkg::EV_RESET;
    end else begin
      flag_q <= flag_d;
      quiet_q <= quiet_d;
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= dog_pkg::BYTE_ZERO;
      strobe_cnt_q <= 3'h0;
      strobe_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      strobe_cnt_q <= strobe_cnt_d;
      strobe_q <= strobe_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign dog_reset_out = biting; // [RL1]
  assign strobe_clk_out = strobe_q;
  assign irq = |(status_q & mask_q);

endmodule : watchdog_reset_timer

`default_nettype wire

// ==== logic/dog_pkg.sv ====
// Package: register map, field layout and constants of the watchdog block
package dog_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] DOG_CONTROL_ADDR = 8'h9F;
  localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'hBF;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hE8;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hE9;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hEA;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hEB;

  // Control register fields
  localparam int ENABLE_POS = 7;
  localparam int CLEAR_POS = 5;
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 3;

  // System control fields
  localparam int DOG_FLAG_POS = 7;
  localparam int QUIET_POS = 0;

  // Interrupt status and mask fields
  localparam int EV_OVERFLOW_POS = 0;
  localparam int EV_HALFWAY_POS = 1;
  localparam int EV_W = 2;

  // Reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 3'h0;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // Counter and prescaler shape
  localparam int COUNT_W = 16;
  localparam int PRESCALE_BASE_LOG2 = 3;
  localparam int PRESCALE_MAX_LOG2 = 10;

  // Address latch strobe runs at the core clock divided by six
  localparam int STROBE_DIV = 6;
  localparam int STROBE_HALF = STROBE_DIV / 2;

  // Length of the reset pulse driven out on overflow
  localparam int BITE_CYCLES = 16;

  typedef enum logic [2:0] {
    DOG_IDLE = 3'b001,
    DOG_RUN = 3'b010,
    DOG_BITE = 3'b100
  } dog_state_t;

endpackage : dog_pkg

// ==== logic/dog_prescaler.sv ====
// Power-of-two time base divider for the watchdog counter
`timescale 1ns/100ps
`default_nettype none

module dog_prescaler #(
  parameter int BASE_LOG2 = dog_pkg::PRESCALE_BASE_LOG2,
  parameter int MAX_LOG2 = dog_pkg::PRESCALE_MAX_LOG2,
  parameter int SEL_W = dog_pkg::PRESCALE_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic restart,
  input wire logic [SEL_W-1:0] select,
  output logic tick
);

  if (MAX_LOG2 - BASE_LOG2 != (1 << SEL_W) - 1) begin : g_bad_range
    $error("dog_prescaler: divider range does not match select width");
  end

  logic [MAX_LOG2-1:0] div_q;
  logic [MAX_LOG2-1:0] div_d;
  wire logic [MAX_LOG2-1:0] last_mask;
  wire logic at_last;

  // Mask of ones below the selected divide-by bit
  assign last_mask = MAX_LOG2'((1 << (BASE_LOG2 + int'(select))) - 1);
  assign at_last = (div_q & last_mask) == last_mask;
  assign tick = run && !restart && at_last;
  assign div_d = (restart || !run || at_last) ? '0 : div_q + 1'b1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

endmodule : dog_prescaler

`default_nettype wire

// ==== tb/watchdog_reset_timer_asserts.sv ====
// Port assertions for the watchdog block
`timescale 1ns/100ps
`default_nettype none
module dog_checker #(
  parameter int COUNT_W = 16,
  parameter int BITE_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic dog_reset_out,
  input wire logic strobe_clk_out,
  input wire logic irq
);
  logic [7:0] bite_q;
  wire rd_ctl = reg_rd && reg_addr == 8'h9F;
  wire rd_sys = reg_rd && reg_addr == 8'hBF;
  wire rd_low = reg_rd && reg_addr == 8'hEA;
  wire clr_wr = reg_wr && reg_addr == 8'h9F && reg_wdata[5];
  wire quiet_wr = reg_wr && reg_addr == 8'hBF && reg_wdata[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Length of the current reset pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) bite_q <= 8'h00;
    else bite_q <= dog_reset_out ? bite_q + 8'h01 : 8'h00;
  end
  a_bite_len: assert property ($fell(dog_reset_out) |-> bite_q == BITE_CYCLES)
    else $error("reset pulse length wrong");
  a_bite_max: assert property (bite_q <= BITE_CYCLES)
    else $error("reset pulse too long");
  a_enable_bite: assert property (dog_reset_out && rd_ctl |=> reg_rdata[7])
    else $error("enable reads zero in reset pulse");
  a_flag_bite: assert property (dog_reset_out && rd_sys |=> reg_rdata[7])
    else $error("reset flag not set in reset pulse");
  a_ctl_spare: assert property (rd_ctl |=> reg_rdata[6:3] == 4'h0)
    else $error("control spare or clear bit reads one");
  a_sys_spare: assert property (rd_sys |=> reg_rdata[6:1] == 6'h00)
    else $error("system control spare bits read one");
  a_clear_zero: assert property (clr_wr ##2 rd_low |=> reg_rdata == 8'h00)
    else $error("count not zero after clear");
  a_irq_mask: assert property (reg_wr && reg_addr == 8'hE9 && reg_wdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with all events masked");
  a_strobe_low: assert property ($fell(strobe_clk_out) |-> !strobe_clk_out [*3])
    else $error("strobe low phase short");
  a_quiet_hold: assert property (quiet_wr && !dog_reset_out |=> ##1 !strobe_clk_out [*3])
    else $error("strobe runs while quiet");
  c_bite: cover property ($rose(dog_reset_out));
  c_irq: cover property ($rose(irq));
  c_clear: cover property (clr_wr ##2 rd_low);
endmodule : dog_checker
bind watchdog_reset_timer dog_checker #(.COUNT_W(COUNT_W), .BITE_CYCLES(BITE_CYCLES)) i_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dog_reset_out(dog_reset_out),
  .strobe_clk_out(strobe_clk_out), .irq(irq)
);
`default_nettype wire

// ==== tb/watchdog_reset_timer_tb_top.sv ====
// Self-checking bench for the watchdog block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module watchdog_reset_timer_tb_top;
  localparam int CW = 4;
  localparam int BC = 2;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic reg_wr = 1'b0, reg_rd = 1'b0, dog_reset_out, strobe_clk_out, irq;
  int fail_count = 0, n_compared = 0, seed = 32'h23D1E699, n, k, c;
  logic [7:0] mdl [256] = '{default: 8'h00};
  logic [7:0] ra [7] = '{8'h9F, 8'hBF, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'h00};
  always #5 core_clk = ~core_clk;
  watchdog_reset_timer #(.COUNT_W(CW), .BITE_CYCLES(BC)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dog_reset_out(dog_reset_out),
    .strobe_clk_out(strobe_clk_out), .irq(irq)
  );
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic chk(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %0h", a), mdl[a], reg_rdata)
    @(posedge core_clk);
  endtask : chk
  task automatic hi(output int h);
    h = 0;
    repeat (6) @(posedge core_clk);
    repeat (12) begin
      @(posedge core_clk);
      #1 h += strobe_clk_out;
    end
    @(posedge core_clk);
  endtask : hi
  // Waits for the overflow pulse and updates the model
  task automatic bite(input int e);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (dog_reset_out !== 1'b1 && n < 40000);
    `CHK("timeout cycles", e, n)
    if (n >= 40000) stop_test();
    // One register read sampled inside the pulse
    k = 0;
    v = c[0] ? 8'h9F : 8'hBF;
    while (dog_reset_out === 1'b1 && k < 300) begin
      @(posedge core_clk);
      reg_addr <= v;
      reg_rd <= (k == 0);
      #1 k++;
      if (k == 2) `CHK("pulse read", mdl[v] | 8'h80, reg_rdata)
    end
    `CHK("pulse cycles", BC, k)
    @(posedge core_clk);
    mdl[8'h9F] = 8'h00;
    mdl[8'hBF] = (mdl[8'hBF] | 8'h80) & 8'hFE;
    mdl[8'hE8] |= 8'h03;
    `CHK("irq", |(mdl[8'hE8] & mdl[8'hE9]), irq)
  endtask : bite
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (ra[i]) chk(ra[i]);
    wr(8'hBF, 8'h01);
    mdl[8'hBF] = 8'h01;
    chk(8'hBF);
    hi(k);
    `CHK("quiet strobe", 0, k)
    wr(8'hBF, 8'h00);
    mdl[8'hBF] = 8'h00;
    hi(k);
    `CHK("strobe highs", 6, k)
    for (c = 0; c < 8; c++) begin
      v = 8'($random(seed));
      wr(8'hE9, v);
      mdl[8'hE9] = v & 8'h03;
      wr(8'h9F, c[7:0]);
      mdl[8'h9F] = c[7:0];
      chk(8'h9F);
      chk(8'hEA);
      v = 8'($random(seed));
      wr(8'h9F, {1'b1, v[6], 1'b0, v[4:3], c[2:0]});
      bite((2 ** CW) * (8 << c) - 1);
      chk(8'h9F);
      chk(8'hBF);
      chk(8'hE8);
      wr(8'hE8, 8'hFF);
      wr(8'hBF, 8'h00);
      mdl[8'hE8] = 8'h00;
      mdl[8'hBF] = 8'h00;
      chk(8'hBF);
      `CHK("irq cleared", 1'b0, irq)
    end
    wr(8'hE9, 8'h01);
    mdl[8'hE9] = 8'h01;
    wr(8'h9F, 8'h80);
    mdl[8'h9F] = 8'h80;
    repeat (10) begin
      repeat (20 + ($random(seed) & 63)) @(posedge core_clk);
      wr(8'h9F, 8'hA0);
      chk(8'hEA);
      chk(8'h9F);
      `CHK("early reset", 1'b0, dog_reset_out)
    end
    wr(8'h9F, 8'hA0);
    bite((2 ** CW) * 8 - 1);
    chk(8'hBF);
    wr(8'hE9, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h9F, 8'h87);
    repeat (50) @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    mdl = '{default: 8'h00};
    foreach (ra[i]) chk(ra[i]);
    stop_test();
  end
endmodule : watchdog_reset_timer_tb_top
`default_nettype wire
